// >>> design/ide_params.svh
`ifndef IDE_PARAMS_SVH
`define IDE_PARAMS_SVH

// register offsets, reset values and write mask in configuration space
`define IDE_OFS_D1_PIO_TIMING 8'h44
`define IDE_OFS_SYNC_DMA_CTRL 8'h48
`define IDE_RST_D1_PIO_TIMING 8'h00
`define IDE_RST_SYNC_DMA_CTRL 8'h00
`define IDE_SYNC_DMA_MASK     8'h0F

// drive1_pio_timing fields
`define IDE_SEC_SAMPLE_HI 7
`define IDE_SEC_SAMPLE_LO 6
`define IDE_SEC_RECOV_HI  5
`define IDE_SEC_RECOV_LO  4
`define IDE_PRI_SAMPLE_HI 3
`define IDE_PRI_SAMPLE_LO 2
`define IDE_PRI_RECOV_HI  1
`define IDE_PRI_RECOV_LO  0

// sync_dma_enable_control fields
`define IDE_PRI_D0_SDMA 0
`define IDE_PRI_D1_SDMA 1
`define IDE_SEC_D0_SDMA 2
`define IDE_SEC_D1_SDMA 3

// timing codes in clocks
`define IDE_SAMPLE_CODE00 4'h5
`define IDE_SAMPLE_CODE01 4'h4
`define IDE_SAMPLE_CODE10 4'h3
`define IDE_SAMPLE_CODE11 4'h5
`define IDE_RECOV_CODE00  4'h4
`define IDE_RECOV_CODE01  4'h3
`define IDE_RECOV_CODE10  4'h2
`define IDE_RECOV_CODE11  4'h1

// compatible timing used when no fast bank is selected
`define IDE_COMPAT_SAMPLE 4'h6
`define IDE_COMPAT_RECOV  4'h8

`define IDE_CNT_W 4

`endif

// >>> design/ide_pkg.sv
package ide_pkg;

  // one PIO access request for a channel
  typedef struct packed {
    logic data_port;
    logic drive1;
    logic write;
  } ide_acc_req_type;

  // fields of the channel main timing register that this block consumes
  typedef struct packed {
    logic       slave_timing_en;
    logic       d0_fast_timing_select;
    logic       d1_fast_timing_select;
    logic [1:0] sample_code;
    logic [1:0] recovery_code;
  } ide_chan_cfg_type;

  typedef enum logic [2:0] {
    IDE_ST_IDLE    = 3'b001,
    IDE_ST_STROBE  = 3'b010,
    IDE_ST_RECOVER = 3'b100
  } ide_pio_state_type;

endpackage

// >>> design/ide_pio_timer.sv
`timescale 1ns/1ps
`include "ide_params.svh"

module ide_pio_timer #(
  parameter int CNT_W = `IDE_CNT_W
) (
  // clock and reset
  input  wire logic             i_core_clk,
  input  wire logic             i_sys_rst,
  // access request
  input  wire logic             i_start,
  input  wire logic             i_write,
  input  wire logic [CNT_W-1:0] i_sample_clks,
  input  wire logic [CNT_W-1:0] i_recovery_clks,
  input  wire logic             i_ready_sync,
  // cable strobes and status
  output logic                  o_read_strobe_n,
  output logic                  o_write_strobe_n,
  output logic                  o_busy,
  output logic                  o_done
);
  import ide_pkg::*;

  ide_pio_state_type state;
  logic [CNT_W-1:0]  cnt;
  logic [CNT_W-1:0]  recov_hold;
  logic              sample_hit;

  // timing is latched at start so a register write mid-cycle cannot stretch it
  logic [CNT_W-1:0]  sample_hold;

  assign sample_hit = (cnt >= sample_hold) && i_ready_sync;

  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      state       <= IDE_ST_IDLE;
      cnt         <= '0;
      sample_hold <= '0;
      recov_hold  <= '0;
    end else begin
      case (state)
        IDE_ST_IDLE: begin
          if (i_start) begin
            state       <= IDE_ST_STROBE;
            cnt         <= CNT_W'(1);
            sample_hold <= i_sample_clks;
            recov_hold  <= i_recovery_clks;
          end
        end
        IDE_ST_STROBE: begin
          // first ready sample lands sample_hold clocks after assertion
          if (sample_hit) begin
            state <= IDE_ST_RECOVER;
            cnt   <= CNT_W'(1);
          end else if (cnt < sample_hold) begin
            cnt <= cnt + CNT_W'(1);
          end
        end
        IDE_ST_RECOVER: begin
          if (cnt >= recov_hold) begin
            state <= IDE_ST_IDLE;
            cnt   <= '0;
          end else begin
            cnt <= cnt + CNT_W'(1);
          end
        end
        default: begin
          state <= IDE_ST_IDLE;
          cnt   <= '0;
        end
      endcase
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      o_read_strobe_n  <= 1'b1;
      o_write_strobe_n <= 1'b1;
    end else if (state == IDE_ST_IDLE && i_start) begin
      o_read_strobe_n  <= i_write;
      o_write_strobe_n <= ~i_write;
    end else if (state == IDE_ST_STROBE && sample_hit) begin
      o_read_strobe_n  <= 1'b1;
      o_write_strobe_n <= 1'b1;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      o_busy <= 1'b0;
      o_done <= 1'b0;
    end else begin
      o_busy <= (state == IDE_ST_IDLE) ? i_start
              : !(state == IDE_ST_RECOVER && cnt >= recov_hold);
      o_done <= (state == IDE_ST_RECOVER) && (cnt >= recov_hold);
    end
  end

endmodule

// >>> design/ide_drive1_timing.sv
`timescale 1ns/1ps
`include "ide_params.svh"

module ide_drive1_timing #(
  parameter int CNT_W = `IDE_CNT_W
) (
  // clock and reset
  input  wire logic                    i_core_clk,
  input  wire logic                    i_sys_rst,
  // configuration space access
  input  wire logic [7:0]              i_cfg_addr,
  input  wire logic                    i_cfg_wr,
  input  wire logic                    i_cfg_rd,
  input  wire logic [7:0]              i_cfg_wdata,
  output logic      [7:0]              o_cfg_rdata,
  // channel main timing fields, index 0 primary, 1 secondary
  input  wire ide_pkg::ide_chan_cfg_type i_chan_cfg [2],
  // PIO access requests per channel
  input  wire logic [1:0]              i_acc_start,
  input  wire ide_pkg::ide_acc_req_type i_acc_req [2],
  output logic      [1:0]              o_acc_busy,
  output logic      [1:0]              o_acc_done,
  // cable pins per channel
  input  wire logic [1:0]              i_drive_ready_line,
  output logic      [1:0]              o_read_strobe_n,
  output logic      [1:0]              o_write_strobe_n,
  // synchronous DMA enables: pri d0, pri d1, sec d0, sec d1
  output logic      [3:0]              o_sync_dma_en
);
  import ide_pkg::*;

  logic [7:0] drive1_pio_timing;
  logic [7:0] sync_dma_enable_control;
  logic [1:0] ready_meta;
  logic [1:0] ready_sync;
  logic [CNT_W-1:0] sel_sample [2];
  logic [CNT_W-1:0] sel_recov  [2];
  logic [1:0] d1_code_sample [2];
  logic [1:0] d1_code_recov  [2];

  function automatic logic [CNT_W-1:0] sample_clocks(input logic [1:0] code);
    case (code)
      2'h0:    sample_clocks = CNT_W'(`IDE_SAMPLE_CODE00);
      2'h1:    sample_clocks = CNT_W'(`IDE_SAMPLE_CODE01);
      2'h2:    sample_clocks = CNT_W'(`IDE_SAMPLE_CODE10);
      default: sample_clocks = CNT_W'(`IDE_SAMPLE_CODE11);
    endcase
  endfunction

  function automatic logic [CNT_W-1:0] recovery_clocks(input logic [1:0] code);
    case (code)
      2'h0:    recovery_clocks = CNT_W'(`IDE_RECOV_CODE00);
      2'h1:    recovery_clocks = CNT_W'(`IDE_RECOV_CODE01);
      2'h2:    recovery_clocks = CNT_W'(`IDE_RECOV_CODE10);
      default: recovery_clocks = CNT_W'(`IDE_RECOV_CODE11);
    endcase
  endfunction

  // configuration writes
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      drive1_pio_timing       <= `IDE_RST_D1_PIO_TIMING;
      sync_dma_enable_control <= `IDE_RST_SYNC_DMA_CTRL;
    end else if (i_cfg_wr) begin
      if (i_cfg_addr == `IDE_OFS_D1_PIO_TIMING) begin
        drive1_pio_timing <= i_cfg_wdata;
      end
      if (i_cfg_addr == `IDE_OFS_SYNC_DMA_CTRL) begin
        sync_dma_enable_control <= i_cfg_wdata & `IDE_SYNC_DMA_MASK;
      end
    end
  end

  // configuration reads, answered one clock after the read strobe
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      o_cfg_rdata <= 8'h00;
    end else if (i_cfg_rd) begin
      case (i_cfg_addr)
        `IDE_OFS_D1_PIO_TIMING: o_cfg_rdata <= drive1_pio_timing;
        `IDE_OFS_SYNC_DMA_CTRL: o_cfg_rdata <= sync_dma_enable_control;
        default:                o_cfg_rdata <= 8'h00;
      endcase
    end
  end

  // enables reach the DMA engines one clock after the register updates
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      o_sync_dma_en <= 4'h0;
    end else begin
      o_sync_dma_en[0] <= sync_dma_enable_control[`IDE_PRI_D0_SDMA];
      o_sync_dma_en[1] <= sync_dma_enable_control[`IDE_PRI_D1_SDMA];
      o_sync_dma_en[2] <= sync_dma_enable_control[`IDE_SEC_D0_SDMA];
      o_sync_dma_en[3] <= sync_dma_enable_control[`IDE_SEC_D1_SDMA];
    end
  end

  // drive ready is asynchronous to the core clock
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      ready_meta <= 2'b00;
      ready_sync <= 2'b00;
    end else begin
      ready_meta <= i_drive_ready_line;
      ready_sync <= ready_meta;
    end
  end

  assign d1_code_sample[0] = drive1_pio_timing[`IDE_PRI_SAMPLE_HI:`IDE_PRI_SAMPLE_LO];
  assign d1_code_recov[0]  = drive1_pio_timing[`IDE_PRI_RECOV_HI:`IDE_PRI_RECOV_LO];
  assign d1_code_sample[1] = drive1_pio_timing[`IDE_SEC_SAMPLE_HI:`IDE_SEC_SAMPLE_LO];
  assign d1_code_recov[1]  = drive1_pio_timing[`IDE_SEC_RECOV_HI:`IDE_SEC_RECOV_LO];

  // timing bank selection per channel
  always_comb begin
    for (int ch = 0; ch < 2; ch++) begin
      logic fast;
      fast = i_acc_req[ch].data_port &&
             (i_acc_req[ch].drive1 ? i_chan_cfg[ch].d1_fast_timing_select
                                   : i_chan_cfg[ch].d0_fast_timing_select);
      if (fast && i_acc_req[ch].drive1 && i_chan_cfg[ch].slave_timing_en) begin
        sel_sample[ch] = sample_clocks(d1_code_sample[ch]);
        sel_recov[ch]  = recovery_clocks(d1_code_recov[ch]);
      end else if (fast) begin
        sel_sample[ch] = sample_clocks(i_chan_cfg[ch].sample_code);
        sel_recov[ch]  = recovery_clocks(i_chan_cfg[ch].recovery_code);
      end else begin
        // compatible timing covers non-data ports and slow drives
        sel_sample[ch] = CNT_W'(`IDE_COMPAT_SAMPLE);
        sel_recov[ch]  = CNT_W'(`IDE_COMPAT_RECOV);
      end
    end
  end

  for (genvar ch = 0; ch < 2; ch++) begin : g_chan
    ide_pio_timer #(
      .CNT_W (CNT_W)
    ) u_timer (
      .i_core_clk       (i_core_clk),
      .i_sys_rst        (i_sys_rst),
      .i_start          (i_acc_start[ch]),
      .i_write          (i_acc_req[ch].write),
      .i_sample_clks    (sel_sample[ch]),
      .i_recovery_clks  (sel_recov[ch]),
      .i_ready_sync     (ready_sync[ch]),
      .o_read_strobe_n  (o_read_strobe_n[ch]),
      .o_write_strobe_n (o_write_strobe_n[ch]),
      .o_busy           (o_acc_busy[ch]),
      .o_done           (o_acc_done[ch])
    );
  end

endmodule

// >>> test/ide_drive_model.sv
`timescale 1ns/1ps
module ide_drive_model (
  // stall request from the bench, per channel
  input  wire logic [1:0] i_hold,
  // cable strobes from the controller
  input  wire logic [1:0] i_read_strobe_n,
  input  wire logic [1:0] i_write_strobe_n,
  // ready back to the controller
  output logic      [1:0] o_drive_ready_line
);
  // a drive only stalls a strobe it sees; otherwise the cable pull-up holds the line high
  assign o_drive_ready_line = ~(i_hold & ~(i_read_strobe_n & i_write_strobe_n));
endmodule

// >>> test/ide_drive1_timing_asserts.sv
`timescale 1ns/1ps
module ide_drive1_timing_asserts (
  // clock, reset and config port
  input wire logic                     i_core_clk,
  input wire logic                     i_sys_rst,
  input wire logic [7:0]               i_cfg_addr,
  input wire logic                     i_cfg_wr,
  input wire logic                     i_cfg_rd,
  input wire logic [7:0]               i_cfg_wdata,
  input wire logic [7:0]               o_cfg_rdata,
  // access side
  input wire logic [1:0]               i_acc_start,
  input wire ide_pkg::ide_acc_req_type i_acc_req [2],
  input wire logic [1:0]               o_acc_busy,
  input wire logic [1:0]               o_acc_done,
  input wire logic [1:0]               o_read_strobe_n,
  input wire logic [1:0]               o_write_strobe_n,
  input wire logic [3:0]               o_sync_dma_en
);
  import ide_pkg::*;
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (i_sys_rst);
  a_rst_clear: assert property ($fell(i_sys_rst) |-> o_sync_dma_en == 4'h0 && o_cfg_rdata == 8'h00)
    else $error("outputs not clear after reset");
  a_dma_follow: assert property (i_cfg_wr && i_cfg_addr == 8'h48 ##1 !i_cfg_wr
    |=> o_sync_dma_en == $past(i_cfg_wdata[3:0], 2)) else $error("dma enables do not follow write");
  a_dma_read: assert property (i_cfg_rd && i_cfg_addr == 8'h48
    |=> o_cfg_rdata == {4'h0, o_sync_dma_en}) else $error("dma register readback wrong");
  a_rd_hold: assert property (!i_cfg_rd |=> $stable(o_cfg_rdata))
    else $error("read data moved without a read");
  a_strb_start: assert property (i_acc_start[0] && !o_acc_busy[0] && !$past(i_acc_start[0])
    |=> o_read_strobe_n[0] == $past(i_acc_req[0].write)
        && o_write_strobe_n[0] == !$past(i_acc_req[0].write)) else $error("wrong strobe at start");
  a_pri_sample: assert property ($fell(o_write_strobe_n[0]) |-> !o_write_strobe_n[0] [*3])
    else $error("primary strobe too short");
  a_sec_sample: assert property ($fell(o_read_strobe_n[1]) |-> !o_read_strobe_n[1] [*3])
    else $error("secondary strobe too short");
  a_recov_gap: assert property ($rose(o_read_strobe_n[0])
    |-> (o_read_strobe_n[0] && o_write_strobe_n[0]) [*2]) else $error("recovery gap too short");
  a_recov_bound: assert property ($rose(o_read_strobe_n[1]) |-> ##[1:8] o_acc_done[1])
    else $error("recovery end late");
  a_done_pulse: assert property (o_acc_done[0] |-> !o_acc_busy[0] ##1 !o_acc_done[0])
    else $error("done pulse malformed");
  c_read_dma: cover property (i_cfg_rd && i_cfg_addr == 8'h48);
  c_slow_strobe: cover property (!o_read_strobe_n[0] [*8]);
  c_sec_done: cover property (o_acc_done[1]);
endmodule

bind ide_drive1_timing ide_drive1_timing_asserts u_chk (.i_core_clk(i_core_clk),
  .i_sys_rst(i_sys_rst), .i_cfg_addr(i_cfg_addr), .i_cfg_wr(i_cfg_wr), .i_cfg_rd(i_cfg_rd),
  .i_cfg_wdata(i_cfg_wdata), .o_cfg_rdata(o_cfg_rdata), .i_acc_start(i_acc_start),
  .i_acc_req(i_acc_req), .o_acc_busy(o_acc_busy), .o_acc_done(o_acc_done),
  .o_read_strobe_n(o_read_strobe_n), .o_write_strobe_n(o_write_strobe_n),
  .o_sync_dma_en(o_sync_dma_en));

// >>> test/ide_drive1_timing_tb.sv
`timescale 1ns/1ps
module ide_drive1_timing_tb;
  import ide_pkg::*;
  logic             clk = 1'h0;
  logic             rst = 1'h1;
  logic             wr = 1'h0;
  logic             rd = 1'h0;
  logic             rdq = 1'h0;
  logic [7:0]       addr = 8'h00;
  logic [7:0]       wd = 8'h00;
  logic [7:0]       r44 = 8'h00;
  logic [7:0]       r48 = 8'h00;
  logic [7:0]       rdat;
  logic [1:0]       st = 2'h0;
  logic [1:0]       hold = 2'h0;
  logic [1:0]       busy, done, rdy, rs_n, ws_n;
  logic [3:0]       dma;
  logic [31:0]      rnd;
  logic [8:0]       e;
  ide_chan_cfg_type ccfg [2] = '{default: '0};
  ide_acc_req_type  req [2] = '{default: '0};
  int               fail_count = 0;
  int               check_count = 0;
  int               seed = 32'h80C08BFA;
  int               cs [2] = '{0, 0};
  int               cr [2] = '{0, 0};
  logic [7:0]       rq [$];
  logic [8:0]       aq [2][$];

  always #12.5 clk = ~clk;

  ide_drive1_timing DUT (.i_core_clk(clk), .i_sys_rst(rst), .i_cfg_addr(addr), .i_cfg_wr(wr),
    .i_cfg_rd(rd), .i_cfg_wdata(wd), .o_cfg_rdata(rdat), .i_chan_cfg(ccfg), .i_acc_start(st),
    .i_acc_req(req), .o_acc_busy(busy), .o_acc_done(done), .i_drive_ready_line(rdy),
    .o_read_strobe_n(rs_n), .o_write_strobe_n(ws_n), .o_sync_dma_en(dma));
  ide_drive_model DRV (.i_hold(hold), .i_read_strobe_n(rs_n), .i_write_strobe_n(ws_n),
    .o_drive_ready_line(rdy));

  task automatic chk(input logic ok, input string m);
    check_count++;
    if (ok !== 1'h1) begin
      fail_count++;
      $display("CHECK FAILED at %0t: %s", $time, m);
    end
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // expected {sample clocks, recovery clocks}; compatible timing is 6/8
  function automatic logic [7:0] tim(input int c, input logic [7:0] t, input ide_chan_cfg_type f,
                                     input ide_acc_req_type q);
    logic [1:0] s, r;
    if (!q.data_port || !(q.drive1 ? f.d1_fast_timing_select : f.d0_fast_timing_select))
      return 8'h68;
    {s, r} = (q.drive1 && f.slave_timing_en) ? (c ? t[7:4] : t[3:0])
                                             : {f.sample_code, f.recovery_code};
    return {((s == 2'h3) ? 4'h5 : 4'h5 - {2'h0, s}), 4'h4 - {2'h0, r}};
  endfunction

  // monitor: measures strobe and recovery lengths seen at the pins
  always @(posedge clk) begin
    rdq <= rd;
    if (rdq)
      chk(rdat === rq.pop_front(), "read data");
    for (int c = 0; c < 2; c++) begin
      if (rst || done[c]) begin
        cs[c] <= 0;
        cr[c] <= 0;
      end else if (!(rs_n[c] && ws_n[c]))
        cs[c] <= cs[c] + 1;
      else if (busy[c])
        cr[c] <= cr[c] + 1;
      if (done[c] && !rst) begin
        e = aq[c].pop_front();
        chk(cr[c] == e[3:0] && (e[8] ? cs[c] > e[7:4] : cs[c] == e[7:4]), "timing");
      end
    end
  end

  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask

  task automatic cfg(input logic w, input logic [7:0] a, input logic [7:0] d);
    addr = a;
    wd = d;
    wr = w;
    rd = !w;
    if (!w)
      rq.push_back(a == 8'h44 ? r44 : (a == 8'h48 ? r48 : 8'h00));
    else if (a == 8'h44)
      r44 = d;
    else if (a == 8'h48)
      r48 = {4'h0, d[3:0]};
    cyc(1);
    wr = 1'h0;
    rd = 1'h0;
    cyc(1);
  endtask

  // a slow access stalls ready for 12 cycles, so only a lower bound on the strobe is known
  task automatic acc(input int c, input logic slow);
    for (int n = 0; n < 40 && busy[c] !== 1'h0; n++)
      cyc(1);
    aq[c].push_back({slow, tim(c, r44, ccfg[c], req[c])});
    st[c] = 1'h1;
    hold[c] = slow;
    cyc(1);
    st[c] = 1'h0;
    cyc(slow ? 12 : 1);
    hold[c] = 1'h0;
  endtask

  initial begin
    cyc(12);
    rst = 1'h0;
    cfg(1'h0, 8'h44, 8'h00);
    cfg(1'h0, 8'h48, 8'h00);
    cfg(1'h1, 8'h48, 8'hFF);
    chk(dma === 4'hF, "dma enables after all-ones write");
    cfg(1'h0, 8'h48, 8'h00);
    cfg(1'h1, 8'h50, 8'hA5);
    cfg(1'h0, 8'h50, 8'h00);
    for (int i = 0; i < 40; i++) begin
      rnd = $random(seed);
      if (rnd[7:6] == 2'h3) rnd[7] = 1'h0;
      if (rnd[3:2] == 2'h3) rnd[3] = 1'h0;
      if (rnd[19:18] == 2'h3) rnd[19] = 1'h0;
      // first passes walk every drive-1 code pair with sample codes 0 to 2 through the slave timing path
      if (i < 24) rnd[7:0] = {2{i[4:3], i[2:1]}};
      if (i < 24) rnd[25:20] = {2'h3, rnd[23], 3'h5};
      cfg(1'h1, 8'h44, rnd[7:0]);
      cfg(1'h1, 8'h48, rnd[15:8]);
      chk(dma === r48[3:0], "dma enables");
      cfg(1'h0, 8'h44, 8'h00);
      cfg(1'h0, 8'h48, 8'h00);
      ccfg[i % 2] = rnd[22:16];
      req[i % 2] = rnd[25:23];
      acc(i % 2, i % 13 == 5);
    end
    acc(0, 1'h1);
    cyc(3);
    rst = 1'h1;
    aq[0].delete();
    r44 = 8'h00;
    r48 = 8'h00;
    cyc(12);
    rst = 1'h0;
    cfg(1'h0, 8'h44, 8'h00);
    cfg(1'h0, 8'h48, 8'h00);
    chk(dma === 4'h0, "dma enables after reset");
    cyc(40);
    end_sim();
  end

  initial begin
    #500000;
    fail_count++;
    end_sim();
  end
endmodule
